// ---- inc/ppc_pkg.sv ----
// constants, register map and field layout of the parallel port pin control block
package ppc_pkg;

  // pin counts
  localparam int PPC_PA_PINS = 4;
  localparam int PPC_PB_PINS = 8;

  // bus geometry
  localparam int PPC_ADDR_W  = 8;
  localparam int PPC_DATA_W  = 32;

  // register byte offsets
  localparam logic [7:0] PPC_OFS_PA_DATA    = 8'h00;
  localparam logic [7:0] PPC_OFS_PA_DIR     = 8'h04;
  localparam logic [7:0] PPC_OFS_PA_PULL    = 8'h08;
  localparam logic [7:0] PPC_OFS_PA_SLEW    = 8'h0C;
  localparam logic [7:0] PPC_OFS_PB_DATA    = 8'h10;
  localparam logic [7:0] PPC_OFS_PB_DIR     = 8'h14;
  localparam logic [7:0] PPC_OFS_PB_DRIVE   = 8'h18;
  localparam logic [7:0] PPC_OFS_PB_IRQCTL  = 8'h1C;
  localparam logic [7:0] PPC_OFS_PB_IRQPIN  = 8'h20;
  localparam logic [7:0] PPC_OFS_PB_EDGE    = 8'h24;
  localparam logic [7:0] PPC_OFS_PB_PULL    = 8'h28;
  localparam logic [7:0] PPC_OFS_IRQ_STATUS = 8'h2C;
  localparam logic [7:0] PPC_OFS_IRQ_MASK   = 8'h30;

  // port b pin interrupt control fields
  localparam int PPC_IRQCTL_FLAG = 3;
  localparam int PPC_IRQCTL_ACK  = 2;
  localparam int PPC_IRQCTL_IE   = 1;
  localparam int PPC_IRQCTL_MODE = 0;

  // sticky status bits
  localparam int PPC_ST_W        = 2;
  localparam int PPC_ST_PB_DET   = 0;
  localparam int PPC_ST_PA_CHG   = 1;

  // reset values
  localparam logic RST_BIT = 1'b0;
  localparam logic [PPC_PA_PINS-1:0] PPC_RST_PA = 4'h0;
  localparam logic [PPC_PB_PINS-1:0] PPC_RST_PB = 8'h00;
  localparam logic [PPC_ST_W-1:0]    PPC_RST_ST = 2'h0;

endpackage

// ---- design/ppc_top.sv ----
// parallel port pin control: direction, buffers, pulls, slew, drive and port b pin interrupt
//
// The placing of the registers and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ps

module ppc_top
  import ppc_pkg::*;
#(
  parameter int PA_W = PPC_PA_PINS,
  parameter int PB_W = PPC_PB_PINS,
  parameter logic [PPC_PA_PINS-1:0] PA_OUT_ONLY = 4'h0,
  parameter logic [PPC_PB_PINS-1:0] PB_OUT_ONLY = 8'h00
)(
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  rstn,
  // avalon-mm slave
  input  wire logic [PPC_ADDR_W-1:0] address,
  input  wire logic                  read,
  input  wire logic                  write,
  input  wire logic [PPC_DATA_W-1:0] writedata,
  input  wire logic [3:0]            byteenable,
  output logic      [PPC_DATA_W-1:0] readdata,
  output logic                       waitrequest,
  // interrupts
  output logic                       irq,
  output logic                       portb_irq_request,
  // port a pins
  input  wire logic [PA_W-1:0]       pin_a_in,
  output logic      [PA_W-1:0]       pin_a_out,
  output logic      [PA_W-1:0]       pin_a_oe_n,
  output logic      [PA_W-1:0]       pin_a_ie,
  output logic      [PA_W-1:0]       pin_a_pull_en,
  output logic      [PA_W-1:0]       pin_a_slew_en,
  // port b pins
  input  wire logic [PB_W-1:0]       pin_b_in,
  output logic      [PB_W-1:0]       pin_b_out,
  output logic      [PB_W-1:0]       pin_b_oe_n,
  output logic      [PB_W-1:0]       pin_b_ie,
  output logic      [PB_W-1:0]       pin_b_pull_en,
  output logic      [PB_W-1:0]       pin_b_pull_up,
  output logic      [PB_W-1:0]       pin_b_high_drive,
  // on-chip peripherals sharing port a
  input  wire logic [PA_W-1:0]       periph_a_en,
  input  wire logic [PA_W-1:0]       periph_a_oe,
  input  wire logic [PA_W-1:0]       periph_a_do,
  input  wire logic [PA_W-1:0]       analog_a_en,
  output logic      [PA_W-1:0]       periph_a_di,
  // on-chip peripherals sharing port b
  input  wire logic [PB_W-1:0]       periph_b_en,
  input  wire logic [PB_W-1:0]       periph_b_oe,
  input  wire logic [PB_W-1:0]       periph_b_do,
  input  wire logic [PB_W-1:0]       analog_b_en,
  output logic      [PB_W-1:0]       periph_b_di
);

  // data read source per bit: latch when output, buffered pin otherwise
  function automatic logic pin_read(input logic dir, input logic latch,
                                    input logic ie, input logic pin);
    pin_read = dir ? latch : (ie & pin);
  endfunction

  // two-stage pin synchronisers
  logic [PA_W-1:0] a_meta_q, a_sync_q, a_prev_q;
  logic [PB_W-1:0] b_meta_q, b_sync_q, b_act_prev_q;
  logic [2:0]      warm_q;

  // software state
  logic [PA_W-1:0] pa_data_q, pa_data_d, pa_dir_q, pa_dir_d;
  logic [PA_W-1:0] pa_pull_q, pa_pull_d, pa_slew_q, pa_slew_d;
  logic [PB_W-1:0] pb_data_q, pb_data_d, pb_dir_q, pb_dir_d;
  logic [PB_W-1:0] pb_drive_q, pb_drive_d, pb_pull_q, pb_pull_d;
  logic [PB_W-1:0] pb_irqpin_q, pb_irqpin_d, pb_edge_q, pb_edge_d;
  logic            pb_ie_q, pb_ie_d, pb_mode_q, pb_mode_d, pb_flag_q, pb_flag_d;
  logic [PPC_ST_W-1:0] st_q, st_d, mask_q, mask_d;
  logic                  wait_q, wait_d;
  logic [PPC_DATA_W-1:0] rdata_q, rdata_d;

  // pin outputs
  logic [PA_W-1:0] a_out_d, a_oe_n_d, a_ie_d, a_pull_d, a_slew_d;
  logic [PA_W-1:0] a_out_q, a_oe_n_q, a_ie_q, a_pull_q, a_slew_q, a_di_q;
  logic [PB_W-1:0] b_out_d, b_oe_n_d, b_ie_d, b_pull_d, b_pu_d, b_hd_d;
  logic [PB_W-1:0] b_out_q, b_oe_n_q, b_ie_q, b_pull_q, b_pu_q, b_hd_q, b_di_q;
  logic            irq_q, irq_d, pbreq_q, pbreq_d;

  // combinational helpers
  logic [PA_W-1:0] a_drv, a_ibuf, a_rd;
  logic [PB_W-1:0] b_drv, b_ibuf, b_act, b_edge, b_rd;
  logic            wr_fire, rd_load, wr_lane0, pb_event, pa_event;

  // buffer control per pin
  always_comb
  begin
    a_drv  = '0;
    a_ibuf = '0;
    for (int i = 0; i < PA_W; i++)
    begin
      if (analog_a_en[i])
      begin
        a_out_d[i]  = RST_BIT;
        a_oe_n_d[i] = 1'b1;
      end
      else if (periph_a_en[i])
      begin
        a_out_d[i]  = periph_a_do[i];
        a_oe_n_d[i] = ~periph_a_oe[i];
        a_drv[i]    = periph_a_oe[i];
      end
      else
      begin
        a_out_d[i]  = pa_data_q[i];
        a_oe_n_d[i] = ~pa_dir_q[i];
        a_drv[i]    = pa_dir_q[i];
      end
      a_ibuf[i]   = ~analog_a_en[i] & ~PA_OUT_ONLY[i];
      a_ie_d[i]   = a_ibuf[i];
      a_rd[i]     = pin_read(pa_dir_q[i], pa_data_q[i], a_ibuf[i], a_sync_q[i]);
      a_pull_d[i] = pa_pull_q[i] & ~a_drv[i] & ~analog_a_en[i];
      a_slew_d[i] = pa_slew_q[i] & a_drv[i];
    end
    b_drv  = '0;
    b_ibuf = '0;
    for (int i = 0; i < PB_W; i++)
    begin
      if (analog_b_en[i])
      begin
        b_out_d[i]  = RST_BIT;
        b_oe_n_d[i] = 1'b1;
      end
      else if (periph_b_en[i])
      begin
        b_out_d[i]  = periph_b_do[i];
        b_oe_n_d[i] = ~periph_b_oe[i];
        b_drv[i]    = periph_b_oe[i];
      end
      else
      begin
        b_out_d[i]  = pb_data_q[i];
        b_oe_n_d[i] = ~pb_dir_q[i];
        b_drv[i]    = pb_dir_q[i];
      end
      b_ibuf[i]   = ~analog_b_en[i] & ~PB_OUT_ONLY[i];
      b_ie_d[i]   = b_ibuf[i];
      b_rd[i]     = pin_read(pb_dir_q[i], pb_data_q[i], b_ibuf[i], b_sync_q[i]);
      b_pull_d[i] = pb_pull_q[i] & ~b_drv[i] & ~analog_b_en[i];
      b_pu_d[i]   = ~pb_edge_q[i];
      b_hd_d[i]   = pb_drive_q[i] & b_drv[i];
    end
  end

  // port b detection and port a change events
  always_comb
  begin
    for (int i = 0; i < PB_W; i++)
    begin
      // rising/high when edge-select is one, falling/low otherwise
      b_act[i] = b_ibuf[i] & ~(b_sync_q[i] ^ pb_edge_q[i]);
    end
    b_edge   = b_act & ~b_act_prev_q;
    // no events until the sync history holds real pin levels, so reset makes no false edge
    pb_event = warm_q[2] & (pb_mode_q ? |(pb_irqpin_q & (b_act | b_edge))
                                      : |(pb_irqpin_q & b_edge));
    pa_event = warm_q[2] & |((a_sync_q ^ a_prev_q) & a_ibuf & ~a_drv);
  end

  // avalon-mm access: one wait cycle, then answer
  always_comb
  begin
    wr_fire  = write & ~wait_q;
    rd_load  = read & wait_q;
    wr_lane0 = wr_fire & byteenable[0];
    wait_d   = ~((read | write) & wait_q);
    rdata_d  = rdata_q;
    if (rd_load)
    begin
      rdata_d = '0;
      unique case (address)
        PPC_OFS_PA_DATA:    rdata_d[PA_W-1:0] = a_rd;
        PPC_OFS_PA_DIR:     rdata_d[PA_W-1:0] = pa_dir_q;
        PPC_OFS_PA_PULL:    rdata_d[PA_W-1:0] = pa_pull_q;
        PPC_OFS_PA_SLEW:    rdata_d[PA_W-1:0] = pa_slew_q;
        PPC_OFS_PB_DATA:    rdata_d[PB_W-1:0] = b_rd;
        PPC_OFS_PB_DIR:     rdata_d[PB_W-1:0] = pb_dir_q;
        PPC_OFS_PB_DRIVE:   rdata_d[PB_W-1:0] = pb_drive_q;
        PPC_OFS_PB_IRQCTL:
        begin
          rdata_d[PPC_IRQCTL_FLAG] = pb_flag_q;
          rdata_d[PPC_IRQCTL_ACK]  = 1'b0;
          rdata_d[PPC_IRQCTL_IE]   = pb_ie_q;
          rdata_d[PPC_IRQCTL_MODE] = pb_mode_q;
        end
        PPC_OFS_PB_IRQPIN:  rdata_d[PB_W-1:0] = pb_irqpin_q;
        PPC_OFS_PB_EDGE:    rdata_d[PB_W-1:0] = pb_edge_q;
        PPC_OFS_PB_PULL:    rdata_d[PB_W-1:0] = pb_pull_q;
        PPC_OFS_IRQ_STATUS: rdata_d[PPC_ST_W-1:0] = st_q;
        PPC_OFS_IRQ_MASK:   rdata_d[PPC_ST_W-1:0] = mask_q;
        default:            rdata_d = '0;
      endcase
    end
  end

  // register writes, flag and status updates
  always_comb
  begin
    pa_data_d   = pa_data_q;
    pa_dir_d    = pa_dir_q;
    pa_pull_d   = pa_pull_q;
    pa_slew_d   = pa_slew_q;
    pb_data_d   = pb_data_q;
    pb_dir_d    = pb_dir_q;
    pb_drive_d  = pb_drive_q;
    pb_irqpin_d = pb_irqpin_q;
    pb_edge_d   = pb_edge_q;
    pb_pull_d   = pb_pull_q;
    pb_ie_d     = pb_ie_q;
    pb_mode_d   = pb_mode_q;
    pb_flag_d   = pb_flag_q;
    st_d        = st_q;
    mask_d      = mask_q;
    if (wr_lane0)
    begin
      unique case (address)
        PPC_OFS_PA_DATA:   pa_data_d   = writedata[PA_W-1:0];
        PPC_OFS_PA_DIR:    pa_dir_d    = writedata[PA_W-1:0];
        PPC_OFS_PA_PULL:   pa_pull_d   = writedata[PA_W-1:0];
        PPC_OFS_PA_SLEW:   pa_slew_d   = writedata[PA_W-1:0];
        PPC_OFS_PB_DATA:   pb_data_d   = writedata[PB_W-1:0];
        PPC_OFS_PB_DIR:    pb_dir_d    = writedata[PB_W-1:0];
        PPC_OFS_PB_DRIVE:  pb_drive_d  = writedata[PB_W-1:0];
        PPC_OFS_PB_IRQPIN: pb_irqpin_d = writedata[PB_W-1:0];
        PPC_OFS_PB_EDGE:   pb_edge_d   = writedata[PB_W-1:0];
        PPC_OFS_PB_PULL:   pb_pull_d   = writedata[PB_W-1:0];
        PPC_OFS_PB_IRQCTL:
        begin
          pb_ie_d   = writedata[PPC_IRQCTL_IE];
          pb_mode_d = writedata[PPC_IRQCTL_MODE];
          if (writedata[PPC_IRQCTL_ACK])
          begin
            pb_flag_d = 1'b0;
          end
        end
        PPC_OFS_IRQ_STATUS: st_d   = st_q & ~writedata[PPC_ST_W-1:0];
        PPC_OFS_IRQ_MASK:   mask_d = writedata[PPC_ST_W-1:0];
        default:            pa_data_d = pa_data_q;
      endcase
    end
    // detection wins over a simultaneous acknowledge or clear
    if (pb_event)
    begin
      pb_flag_d = 1'b1;
      st_d[PPC_ST_PB_DET] = 1'b1;
    end
    if (pa_event)
    begin
      st_d[PPC_ST_PA_CHG] = 1'b1;
    end
    pbreq_d = pb_flag_q & pb_ie_q;
    irq_d   = |(st_q & mask_q);
  end

  // software state and bus answer
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      pa_data_q   <= PPC_RST_PA;
      pa_dir_q    <= PPC_RST_PA;
      pa_pull_q   <= PPC_RST_PA;
      pa_slew_q   <= PPC_RST_PA;
      pb_data_q   <= PPC_RST_PB;
      pb_dir_q    <= PPC_RST_PB;
      pb_drive_q  <= PPC_RST_PB;
      pb_irqpin_q <= PPC_RST_PB;
      pb_edge_q   <= PPC_RST_PB;
      pb_pull_q   <= PPC_RST_PB;
      pb_ie_q     <= RST_BIT;
      pb_mode_q   <= RST_BIT;
      pb_flag_q   <= RST_BIT;
      st_q        <= PPC_RST_ST;
      mask_q      <= PPC_RST_ST;
      wait_q      <= 1'b1;
      rdata_q     <= '0;
    end
    else
    begin
      pa_data_q   <= pa_data_d;
      pa_dir_q    <= pa_dir_d;
      pa_pull_q   <= pa_pull_d;
      pa_slew_q   <= pa_slew_d;
      pb_data_q   <= pb_data_d;
      pb_dir_q    <= pb_dir_d;
      pb_drive_q  <= pb_drive_d;
      pb_irqpin_q <= pb_irqpin_d;
      pb_edge_q   <= pb_edge_d;
      pb_pull_q   <= pb_pull_d;
      pb_ie_q     <= pb_ie_d;
      pb_mode_q   <= pb_mode_d;
      pb_flag_q   <= pb_flag_d;
      st_q        <= st_d;
      mask_q      <= mask_d;
      wait_q      <= wait_d;
      rdata_q     <= rdata_d;
    end
  end

  // synchronisers, registered pin and interrupt outputs
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      a_meta_q     <= PPC_RST_PA;
      a_sync_q     <= PPC_RST_PA;
      a_prev_q     <= PPC_RST_PA;
      b_meta_q     <= PPC_RST_PB;
      b_sync_q     <= PPC_RST_PB;
      b_act_prev_q <= PPC_RST_PB;
      warm_q       <= '0;
      a_out_q  <= PPC_RST_PA;
      a_oe_n_q <= ~PPC_RST_PA;
      a_ie_q   <= ~PPC_RST_PA;
      a_pull_q <= PPC_RST_PA;
      a_slew_q <= PPC_RST_PA;
      a_di_q   <= PPC_RST_PA;
      b_out_q  <= PPC_RST_PB;
      b_oe_n_q <= ~PPC_RST_PB;
      b_ie_q   <= ~PPC_RST_PB;
      b_pull_q <= PPC_RST_PB;
      b_pu_q   <= ~PPC_RST_PB;
      b_hd_q   <= PPC_RST_PB;
      b_di_q   <= PPC_RST_PB;
      irq_q    <= RST_BIT;
      pbreq_q  <= RST_BIT;
    end
    else
    begin
      a_meta_q     <= pin_a_in;
      a_sync_q     <= a_meta_q;
      a_prev_q     <= a_sync_q;
      b_meta_q     <= pin_b_in;
      b_sync_q     <= b_meta_q;
      b_act_prev_q <= b_act;
      warm_q       <= {warm_q[1:0], 1'b1};
      a_out_q  <= a_out_d;
      a_oe_n_q <= a_oe_n_d;
      a_ie_q   <= a_ie_d;
      a_pull_q <= a_pull_d;
      a_slew_q <= a_slew_d;
      a_di_q   <= a_sync_q & a_ibuf;
      b_out_q  <= b_out_d;
      b_oe_n_q <= b_oe_n_d;
      b_ie_q   <= b_ie_d;
      b_pull_q <= b_pull_d;
      b_pu_q   <= b_pu_d;
      b_hd_q   <= b_hd_d;
      b_di_q   <= b_sync_q & b_ibuf;
      irq_q    <= irq_d;
      pbreq_q  <= pbreq_d;
    end
  end

  assign readdata          = rdata_q;
  assign waitrequest       = wait_q;
  assign irq               = irq_q;
  assign portb_irq_request = pbreq_q;
  assign pin_a_out         = a_out_q;
  assign pin_a_oe_n        = a_oe_n_q;
  assign pin_a_ie          = a_ie_q;
  assign pin_a_pull_en     = a_pull_q;
  assign pin_a_slew_en     = a_slew_q;
  assign periph_a_di       = a_di_q;
  assign pin_b_out         = b_out_q;
  assign pin_b_oe_n        = b_oe_n_q;
  assign pin_b_ie          = b_ie_q;
  assign pin_b_pull_en     = b_pull_q;
  assign pin_b_pull_up     = b_pu_q;
  assign pin_b_high_drive  = b_hd_q;
  assign periph_b_di       = b_di_q;

endmodule // ppc_top

// ---- bench/ppc_checker.sv ----
// port-level assertions for the parallel port pin control block
`timescale 1ns/1ps
module ppc_checker
  import ppc_pkg::*;
#(
  parameter int PA_W = PPC_PA_PINS,
  parameter int PB_W = PPC_PB_PINS
)(
  // clock, reset and bus
  input wire logic                  clock,
  input wire logic                  rstn,
  input wire logic [PPC_ADDR_W-1:0] address,
  input wire logic                  read,
  input wire logic                  write,
  input wire logic [PPC_DATA_W-1:0] readdata,
  input wire logic                  waitrequest,
  input wire logic                  irq,
  // port a
  input wire logic [PA_W-1:0]       pin_a_out,
  input wire logic [PA_W-1:0]       pin_a_oe_n,
  input wire logic [PA_W-1:0]       pin_a_ie,
  input wire logic [PA_W-1:0]       pin_a_pull_en,
  input wire logic [PA_W-1:0]       pin_a_slew_en,
  input wire logic [PA_W-1:0]       periph_a_en,
  input wire logic [PA_W-1:0]       periph_a_oe,
  input wire logic [PA_W-1:0]       periph_a_do,
  input wire logic [PA_W-1:0]       analog_a_en,
  // port b
  input wire logic [PB_W-1:0]       pin_b_oe_n,
  input wire logic [PB_W-1:0]       pin_b_high_drive
);
  logic [PA_W-1:0] dig_a;
  logic            wr_acc;
  logic            rd_acc;
  assign dig_a  = periph_a_en & ~analog_a_en;
  assign wr_acc = write & ~waitrequest;
  assign rd_acc = read & ~waitrequest;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  sequence s_req;
    (read || write) && waitrequest;
  endsequence
  sequence s_ans;
    !waitrequest ##1 waitrequest;
  endsequence

  a_bus_answer: assert property (s_req |=> s_ans)
    else $error("bus answer not a single cycle");
  a_analog_off: assert property ($past(rstn) |->
    (pin_a_oe_n | ~$past(analog_a_en)) == '1 && (pin_a_ie & $past(analog_a_en)) == '0)
    else $error("analog pin buffers not off");
  a_periph_drives: assert property ($past(rstn) |->
    ((pin_a_oe_n ^ ~$past(periph_a_oe)) & $past(dig_a)) == '0
    && ((pin_a_out ^ $past(periph_a_do)) & $past(dig_a)) == '0)
    else $error("peripheral not driving its pin");
  a_pull_driven: assert property ((pin_a_pull_en & ~pin_a_oe_n) == '0)
    else $error("pull on while driving");
  a_drive_inputs: assert property ((pin_a_slew_en & pin_a_oe_n) == '0
    && (pin_b_high_drive & pin_b_oe_n) == '0)
    else $error("slew or drive on an input pin");
  a_irq_fall: assert property ($fell(irq) |-> $past(wr_acc, 2))
    else $error("irq dropped without a write");
  a_ack_zero: assert property (rd_acc && address == PPC_OFS_PB_IRQCTL |->
    readdata[PPC_DATA_W-1:4] == '0 && readdata[PPC_IRQCTL_ACK] == 1'b0)
    else $error("acknowledge bit read back nonzero");
  a_rsvd_zero: assert property (rd_acc
    && (address == PPC_OFS_PA_PULL || address == PPC_OFS_PA_SLEW) |-> readdata[7:4] == 4'h0)
    else $error("unused port a bits read nonzero");
  a_reset_state: assert property (!$past(rstn) |-> pin_a_oe_n == '1
    && pin_a_pull_en == '0 && pin_a_slew_en == '0 && pin_b_high_drive == '0)
    else $error("pin state wrong after reset");
endmodule // ppc_checker

bind ppc_top ppc_checker #(.PA_W(PA_W), .PB_W(PB_W)) u_chk (.*);

// ---- bench/ppc_pins_model.sv ----
// board model: resolves each pin from chip drive, board drive and pulls
`timescale 1ns/1ps
module ppc_pins_model #(
  parameter int W = 8
)(
  // clock and reset
  input wire logic         clock,
  input wire logic         rstn,
  // chip side
  input wire logic [W-1:0] oe_n,
  input wire logic [W-1:0] out,
  input wire logic [W-1:0] pull_en,
  input wire logic [W-1:0] pull_up,
  // board side
  input wire logic [W-1:0] ext_en,
  input wire logic [W-1:0] ext_val,
  // resolved level
  output logic     [W-1:0] level
);
  logic [W-1:0] last_q;
  logic [W-1:0] last_d;
  always_comb
  begin
    for (int i = 0; i < W; i++)
    begin
      if (!oe_n[i])
        level[i] = out[i];
      else if (ext_en[i])
        level[i] = ext_val[i];
      else if (pull_en[i])
        level[i] = pull_up[i];
      else
        level[i] = ~last_q[i]; // a floating pin does not keep its old level
      last_d[i] = (oe_n[i] && !ext_en[i] && !pull_en[i]) ? last_q[i] : level[i];
    end
  end
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
      last_q <= '0;
    else
      last_q <= last_d;
endmodule // ppc_pins_model

// ---- bench/ppc_top_tb.sv ----
// self-checking bench for the parallel port pin control block
`timescale 1ns/1ps
module ppc_top_tb;
  import ppc_pkg::*;
  // bus and interrupts
  logic        clock, rstn, read, write, waitrequest, irq, portb_irq_request;
  logic [7:0]  address;
  logic [31:0] writedata, readdata, rv;
  logic [3:0]  byteenable;
  // port a
  logic [3:0]  pin_a_in, pin_a_out, pin_a_oe_n, pin_a_ie, pin_a_pull_en, pin_a_slew_en;
  logic [3:0]  periph_a_en, periph_a_oe, periph_a_do, analog_a_en, periph_a_di;
  // port b
  logic [7:0]  pin_b_in, pin_b_out, pin_b_oe_n, pin_b_ie, pin_b_pull_en, pin_b_pull_up;
  logic [7:0]  pin_b_high_drive, periph_b_en, periph_b_oe, periph_b_do, analog_b_en;
  logic [7:0]  periph_b_di, ext_b_en, ext_b_v;
  int          err_total, n_checks;

  ppc_top dut (.*);
  ppc_pins_model #(.W(4)) u_pa (.clock(clock), .rstn(rstn), .oe_n(pin_a_oe_n),
    .out(pin_a_out), .pull_en(pin_a_pull_en), .pull_up(4'hF), .ext_en(4'h0),
    .ext_val(4'h0), .level(pin_a_in));
  ppc_pins_model #(.W(8)) u_pb (.clock(clock), .rstn(rstn), .oe_n(pin_b_oe_n),
    .out(pin_b_out), .pull_en(pin_b_pull_en), .pull_up(pin_b_pull_up),
    .ext_en(ext_b_en), .ext_val(ext_b_v), .level(pin_b_in));

  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  initial
  begin
    #50000;
    err_total++;
    end_sim();
  end

  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one avalon access; request held until waitrequest is seen low
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    address <= a;
    read <= !w;
    write <= w;
    writedata <= d;
    do
      @(posedge clock);
    while (waitrequest !== 1'b0);
    rv = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    chk(rv, exp);
  endtask

  // two sync stages, detect and request register
  task automatic settle();
    repeat (4) @(posedge clock);
  endtask

  initial
  begin
    {rstn, read, write, address, writedata} = '0;
    byteenable = 4'hF;
    {periph_a_en, periph_a_oe, periph_a_do, analog_a_en} = '0;
    {periph_b_en, periph_b_oe, periph_b_do, analog_b_en, ext_b_en, ext_b_v} = '0;
    err_total = 0;
    n_checks = 0;
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    rd(PPC_OFS_PA_PULL, 32'h0);
    rd(PPC_OFS_PA_SLEW, 32'h0);
    rd(PPC_OFS_PB_DRIVE, 32'h0);
    rd(PPC_OFS_PB_IRQCTL, 32'h0);
    chk(32'(pin_a_oe_n), 32'hF);
    bus(PPC_OFS_PA_PULL, 1'b1, 32'hFF);
    rd(PPC_OFS_PA_PULL, 32'hF);
    bus(PPC_OFS_PA_SLEW, 1'b1, 32'hFF);
    rd(PPC_OFS_PA_SLEW, 32'hF);
    bus(PPC_OFS_PB_DRIVE, 1'b1, 32'hA5);
    rd(PPC_OFS_PB_DRIVE, 32'hA5);
    bus(8'h3C, 1'b1, 32'hFF);
    rd(8'h3C, 32'h0);
    // direction, pulls, slew and drive
    bus(PPC_OFS_PA_DIR, 1'b1, 32'h3);
    bus(PPC_OFS_PA_DATA, 1'b1, 32'h5);
    bus(PPC_OFS_PB_DIR, 1'b1, 32'hF);
    bus(PPC_OFS_PB_DATA, 1'b1, 32'h3);
    settle();
    chk(32'(pin_a_oe_n), 32'hC);
    chk(32'(pin_b_oe_n), 32'hF0);
    chk(32'(pin_b_out), 32'h03);
    rd(PPC_OFS_PB_DATA, 32'hF3);
    chk(32'(pin_a_pull_en), 32'hC);
    chk(32'(pin_a_slew_en), 32'h3);
    chk(32'(pin_b_high_drive), 32'h05);
    rd(PPC_OFS_PA_DATA, 32'hD);
    // shared digital and analog functions
    periph_a_en <= 4'h3;
    periph_a_oe <= 4'h1;
    periph_a_do <= 4'h1;
    analog_a_en <= 4'hA;
    analog_b_en <= 8'h81;
    settle();
    chk(32'(pin_a_oe_n), 32'hE);
    chk(32'(pin_b_oe_n), 32'hF1);
    chk(32'(pin_b_ie), 32'h7E);
    chk(32'(periph_a_di), 32'h5);
    chk(32'(pin_a_ie), 32'h5);
    chk(32'(pin_a_out[0]), 32'h1);
    rd(PPC_OFS_PA_DATA, 32'h5);
    periph_a_en <= 4'h0;
    analog_a_en <= 4'h0;
    analog_b_en <= 8'h00;
    // port b pin interrupt
    bus(PPC_OFS_PB_DIR, 1'b1, 32'h0);
    bus(PPC_OFS_PB_IRQPIN, 1'b1, 32'h1);
    bus(PPC_OFS_PB_EDGE, 1'b1, 32'h1);
    bus(PPC_OFS_PB_PULL, 1'b1, 32'h1);
    ext_b_en <= 8'h01;
    settle();
    chk(32'(pin_b_pull_up), 32'hFE);
    chk(32'(pin_b_pull_en), 32'h01);
    bus(PPC_OFS_IRQ_STATUS, 1'b1, 32'h3);
    bus(PPC_OFS_IRQ_MASK, 1'b1, 32'h1);
    bus(PPC_OFS_PB_IRQCTL, 1'b1, 32'h6);
    rd(PPC_OFS_PB_IRQCTL, 32'h2);
    ext_b_v <= 8'h01;
    settle();
    rd(PPC_OFS_PB_IRQCTL, 32'hA);
    chk({30'h0, portb_irq_request, irq}, 32'h3);
    chk(32'(periph_b_di[0]), 32'h1);
    bus(PPC_OFS_PB_IRQCTL, 1'b1, 32'h0);
    settle();
    rd(PPC_OFS_PB_IRQCTL, 32'h8);
    chk(32'(portb_irq_request), 32'h0);
    bus(PPC_OFS_PB_IRQCTL, 1'b1, 32'h6);
    rd(PPC_OFS_PB_IRQCTL, 32'h2);
    rd(PPC_OFS_IRQ_STATUS, 32'h1);
    bus(PPC_OFS_IRQ_MASK, 1'b1, 32'h0);
    settle();
    chk(32'(irq), 32'h0);
    bus(PPC_OFS_IRQ_MASK, 1'b1, 32'h1);
    settle();
    chk(32'(irq), 32'h1);
    bus(PPC_OFS_IRQ_STATUS, 1'b1, 32'h1);
    settle();
    chk(32'(irq), 32'h0);
    bus(PPC_OFS_PB_IRQCTL, 1'b1, 32'h7);
    settle();
    rd(PPC_OFS_PB_IRQCTL, 32'hB);
    // falling polarity with pull-up
    bus(PPC_OFS_PB_EDGE, 1'b1, 32'h0);
    settle();
    bus(PPC_OFS_PB_IRQCTL, 1'b1, 32'h6);
    settle();
    chk(32'(pin_b_pull_up), 32'hFF);
    rd(PPC_OFS_PB_IRQCTL, 32'h2);
    ext_b_v <= 8'h00;
    settle();
    rd(PPC_OFS_PB_IRQCTL, 32'hA);
    end_sim();
  end
endmodule // ppc_top_tb
